// >>> rtl/pra_map.svh
`ifndef PRA_MAP_SVH
`define PRA_MAP_SVH

// ----------------------------------------------------------------
// device register map, full 11-bit addresses {page, offset}; the page selector is a 7-bit offset
// ----------------------------------------------------------------
`define PRA_PAGE_SEL 7'h7f
`define PRA_PAGE_RST 8'h00
`define PRA_TRIM_MSB 11'h00b
`define PRA_TRIM_B1 11'h00c
`define PRA_TRIM_B2 11'h00d
`define PRA_TRIM_LSB 11'h00e
`define PRA_TRIM_RST 32'h046a_aaab
`define PRA_HOLD 11'h180
`define PRA_HOLD_ON 8'h01
`define PRA_HOLD_RST 8'h00
`define PRA_STICKY 11'h181
`define PRA_FINE_DUR 11'h420
`define PRA_FINE_STAT 11'h421
`define PRA_LOOP_LO 11'h300
`define PRA_LOOP_HI 11'h31f

// ----------------------------------------------------------------
// controller registers on the avalon side (byte addresses)
// ----------------------------------------------------------------
`define PRA_AV_ADDR 4'h0
`define PRA_AV_WDATA 4'h4
`define PRA_AV_CTRL 4'h8
`define PRA_AV_STAT 4'hc
`define PRA_CTRL_GO 0
`define PRA_CTRL_WE 1
`define PRA_STAT_BUSY 0
`define PRA_STAT_OERR 1
`define PRA_STAT_RD_LSB 8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PRA_CLK_NS 10
`define PRA_FINE_UNIT_NS 286720
`define PRA_FINE_UNIT_CYC (`PRA_FINE_UNIT_NS / `PRA_CLK_NS)
`define PRA_SAME_GAP_MS 25
`define PRA_SAME_GAP_CYC (`PRA_SAME_GAP_MS * 1000000 / `PRA_CLK_NS)
`define PRA_LOOP_GAP_US 600
`define PRA_LOOP_GAP_CYC (`PRA_LOOP_GAP_US * 1000 / `PRA_CLK_NS)
`define PRA_SETTLE_MS 100
`define PRA_SETTLE_CYC (`PRA_SETTLE_MS * 1000000 / `PRA_CLK_NS)

`endif

// >>> rtl/pra_pkg.sv
package pra_pkg;
   typedef logic [10:0] pra_addr_t;
   typedef logic [7:0] pra_byte_t;
   typedef enum {
      S_IDLE,
      S_START,
      S_PWAIT,
      S_GAP,
      S_AWAIT
   } pra_hst_state_t;
endpackage

// >>> rtl/pra_link_if.sv
`timescale 1ns/1ps
// byte-wide register link standing in for the serial port framing
interface pra_link_if;
   logic req;
   logic we;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   modport dev (input req, we, addr, wdata, output ack, rdata);
   modport host (output req, we, addr, wdata, input ack, rdata);
endinterface

// >>> rtl/pra_device.sv
`timescale 1ns/1ps
// Notes on behaviour
// - every register is one byte wide
// - wide values big-endian, msb lowest address
// - host accesses msb first, lsb last
// - earlier bytes held, value applied on lsb
// - trim at 0x00b..0x00e, resets 0x046aaaab
// - same-register writes spaced at least 25ms
// - loop offset words rewritable every 600us
// - page selector takes back-to-back writes
// - wait after state-machine config before others
// - trim value not changed during operation
// - lock, clear, unlock, wait, read sticky
// - fine shift duration counts 286.72us units
// - pages of 127, selector at 0x7f
`include "pra_map.svh"

module pra_device
   import pra_pkg::*;
#(
   parameter int FINE_UNIT_CYC = `PRA_FINE_UNIT_CYC
) (
   // link to the host
   pra_link_if.dev link,
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // monitored events, one-cycle or level
   input wire logic [7:0] sticky_event,
   // applied state
   output logic [31:0] trim_value,
   output logic [7:0] page_sel,
   output logic fine_shift_busy
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] page_q;
   logic [23:0] stage_q;
   logic [31:0] trim_q;
   logic [23:0] snap_q;
   logic [7:0] hold_q;
   logic [7:0] sticky_q;
   logic [7:0] sticky_d;
   logic [7:0] dur_q;
   logic [7:0] left_q;
   logic [15:0] unit_q;
   logic busy_q;
   logic ack_q;
   logic [7:0] rdata_q;
   pra_byte_t rd_byte;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // selector answers at 0x7f of every page, whatever page is mapped
   pra_addr_t full_addr;
   wire is_page = link.addr == `PRA_PAGE_SEL;
   wire wr_hit = link.req & link.we;
   wire rd_hit = link.req & ~link.we;
   assign full_addr = {page_q[3:0], link.addr};
   wire wr_page = wr_hit & is_page;
   wire wr_msb = wr_hit & ~is_page & (full_addr == `PRA_TRIM_MSB);
   wire wr_b1 = wr_hit & ~is_page & (full_addr == `PRA_TRIM_B1);
   wire wr_b2 = wr_hit & ~is_page & (full_addr == `PRA_TRIM_B2);
   wire wr_lsb = wr_hit & ~is_page & (full_addr == `PRA_TRIM_LSB);
   wire rd_msb = rd_hit & ~is_page & (full_addr == `PRA_TRIM_MSB);
   wire wr_hold = wr_hit & ~is_page & (full_addr == `PRA_HOLD);
   wire wr_sticky = wr_hit & ~is_page & (full_addr == `PRA_STICKY);
   wire wr_fine = wr_hit & ~is_page & (full_addr == `PRA_FINE_DUR);
   wire unit_last = unit_q == 16'(FINE_UNIT_CYC - 1);
   wire hold_on = hold_q == `PRA_HOLD_ON;

   // ----------------------------------------------------------------
   // read selection
   // ----------------------------------------------------------------
   // bytes after the msb come from a snapshot taken at the msb read,
   // so a multi-byte read is coherent even if the value moves
   always_comb begin
      rd_byte = 8'h00;
      if (is_page) begin
         rd_byte = page_q;
      end else begin
         case (full_addr)
            `PRA_TRIM_MSB: rd_byte = trim_q[31:24];
            `PRA_TRIM_B1: rd_byte = snap_q[23:16];
            `PRA_TRIM_B2: rd_byte = snap_q[15:8];
            `PRA_TRIM_LSB: rd_byte = snap_q[7:0];
            `PRA_HOLD: rd_byte = hold_q;
            `PRA_STICKY: rd_byte = sticky_q;
            `PRA_FINE_DUR: rd_byte = dur_q;
            `PRA_FINE_STAT: rd_byte = {7'h00, busy_q};
            default: rd_byte = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // link answer
   // ----------------------------------------------------------------
   // every access answered one cycle later, never stalled
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ack_q <= link.req;
         if (rd_hit) begin
            rdata_q <= rd_byte;
         end
      end
   end

   assign link.ack = ack_q;
   assign link.rdata = rdata_q;

   // page selector, no spacing needed between writes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         page_q <= `PRA_PAGE_RST;
      end else if (wr_page) begin
         page_q <= link.wdata;
      end
   end

   // ----------------------------------------------------------------
   // wide trim value
   // ----------------------------------------------------------------
   // upper bytes wait in staging; a stray lsb write applies stale
   // staging, which is why the host must keep msb-first order
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_q <= 24'(`PRA_TRIM_RST >> 8);
      end else begin
         if (wr_msb) begin
            stage_q[23:16] <= link.wdata;
         end
         if (wr_b1) begin
            stage_q[15:8] <= link.wdata;
         end
         if (wr_b2) begin
            stage_q[7:0] <= link.wdata;
         end
      end
   end

   // whole value applied only by the lsb write
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         trim_q <= `PRA_TRIM_RST;
      end else if (wr_lsb) begin
         trim_q <= {stage_q, link.wdata};
      end
   end

   // snapshot of the lower bytes at the msb read
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         snap_q <= 24'(`PRA_TRIM_RST);
      end else if (rd_msb) begin
         snap_q <= trim_q[23:0];
      end
   end

   // ----------------------------------------------------------------
   // sticky status with hold register
   // ----------------------------------------------------------------
   // zero bits of a write clear only while the hold is on;
   // an event in the same cycle as its clear keeps the bit set
   wire [7:0] sticky_clr = (wr_sticky & hold_on) ? ~link.wdata : 8'h00;
   assign sticky_d = (sticky_q & ~sticky_clr) | sticky_event;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_q <= `PRA_HOLD_RST;
         sticky_q <= 8'h00;
      end else begin
         if (wr_hold) begin
            hold_q <= link.wdata;
         end
         sticky_q <= sticky_d;
      end
   end

   // ----------------------------------------------------------------
   // fine phase shift duration timer
   // ----------------------------------------------------------------
   // busy for exactly duration * unit cycles; rewriting restarts it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dur_q <= 8'h00;
         left_q <= 8'h00;
         busy_q <= 1'b0;
      end else if (wr_fine) begin
         dur_q <= link.wdata;
         left_q <= link.wdata;
         busy_q <= link.wdata != 8'h00;
      end else if (busy_q && unit_last) begin
         left_q <= left_q - 8'h01;
         busy_q <= left_q != 8'h01;
      end
   end

   // unit counter limits the parameter to 65536 cycles per unit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         unit_q <= 16'h0000;
      end else if (wr_fine || !busy_q || unit_last) begin
         unit_q <= 16'h0000;
      end else begin
         unit_q <= unit_q + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // user-side outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         trim_value <= `PRA_TRIM_RST;
         page_sel <= `PRA_PAGE_RST;
         fine_shift_busy <= 1'b0;
      end else begin
         trim_value <= trim_q;
         page_sel <= page_q;
         fine_shift_busy <= busy_q;
      end
   end

endmodule

// >>> rtl/pra_host.sv
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`include "pra_map.svh"

module pra_host
   import pra_pkg::*;
#(
   parameter int SAME_GAP_CYC = `PRA_SAME_GAP_CYC,
   parameter int LOOP_GAP_CYC = `PRA_LOOP_GAP_CYC,
   parameter int SETTLE_CYC = `PRA_SETTLE_CYC
) (
   // link to the device
   pra_link_if.host link,
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   pra_hst_state_t state_q;
   pra_hst_state_t state_d;
   pra_addr_t cmd_addr_q;
   logic [7:0] cmd_wd_q;
   logic cmd_we_q;
   logic err_q;
   logic [7:0] rd_q;
   logic [3:0] page_q;
   pra_addr_t exp_q;
   pra_addr_t last_q;
   logic settle_q;
   logic [23:0] gap_q;
   logic req_q;
   logic we_q;
   logic [6:0] addr_q;
   logic [7:0] wd_q;
   logic req_d;
   logic we_d;
   logic [6:0] addr_d;
   logic [7:0] wd_d;

   // ----------------------------------------------------------------
   // avalon decode
   // ----------------------------------------------------------------
   // one wait cycle per access keeps readdata a registered output
   wire av_req = (avs_read | avs_write) & avs_waitrequest;
   wire av_wr = avs_write & ~avs_waitrequest;
   wire idle = state_q == S_IDLE;
   wire wr_addr = av_wr & (avs_address == `PRA_AV_ADDR) & idle;
   wire wr_wd = av_wr & (avs_address == `PRA_AV_WDATA) & idle;
   wire wr_ctrl = av_wr & (avs_address == `PRA_AV_CTRL) & idle;
   wire go = wr_ctrl & avs_writedata[`PRA_CTRL_GO];
   wire clr_err = av_wr & (avs_address == `PRA_AV_STAT) & avs_writedata[`PRA_STAT_OERR];
   wire [31:0] stat_word = {16'h0000, rd_q, 6'h00, err_q, ~idle};
   wire [31:0] rd_word = (avs_address == `PRA_AV_ADDR) ? {21'h0, cmd_addr_q} :
      (avs_address == `PRA_AV_WDATA) ? {24'h00_0000, cmd_wd_q} :
      (avs_address == `PRA_AV_CTRL) ? {30'h0, cmd_we_q, 1'b0} :
      (avs_address == `PRA_AV_STAT) ? stat_word : 32'h0000_0000;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= ~av_req;
         if (av_req) begin
            avs_readdata <= rd_word;
         end
      end
   end

   // command registers, writable only while idle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_addr_q <= 11'h000;
         cmd_wd_q <= 8'h00;
         cmd_we_q <= 1'b0;
      end else begin
         if (wr_addr) begin
            cmd_addr_q <= avs_writedata[10:0];
         end
         if (wr_wd) begin
            cmd_wd_q <= avs_writedata[7:0];
         end
         if (wr_ctrl) begin
            cmd_we_q <= avs_writedata[`PRA_CTRL_WE];
         end
      end
   end

   // ----------------------------------------------------------------
   // order check on the wide trim value
   // ----------------------------------------------------------------
   wire in_trim = (cmd_addr_q >= `PRA_TRIM_MSB) && (cmd_addr_q <= `PRA_TRIM_LSB);
   wire start = state_q == S_START;
   wire bad_order = start & in_trim & (cmd_addr_q != exp_q);
   wire [10:0] exp_next = (cmd_addr_q == `PRA_TRIM_LSB || bad_order) ?
      `PRA_TRIM_MSB : cmd_addr_q + 11'h001;

   // error flag: a new fault beats a clear in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         exp_q <= `PRA_TRIM_MSB;
         err_q <= 1'b0;
      end else begin
         if (start && in_trim) begin
            exp_q <= exp_next;
         end
         err_q <= bad_order | (err_q & ~clr_err);
      end
   end

   // ----------------------------------------------------------------
   // write spacing
   // ----------------------------------------------------------------
   // page select and reads never wait; a repeated register waits 25ms,
   // loop offset words 600us, any write after the trim lsb the settle
   wire is_sel = cmd_addr_q[6:0] == `PRA_PAGE_SEL;
   wire in_loop = (cmd_addr_q >= `PRA_LOOP_LO) && (cmd_addr_q <= `PRA_LOOP_HI);
   wire same = cmd_addr_q == last_q;
   wire [23:0] need_same = !same ? 24'h00_0000 :
      in_loop ? 24'(LOOP_GAP_CYC) : 24'(SAME_GAP_CYC);
   wire [23:0] need = (settle_q && need_same < 24'(SETTLE_CYC)) ?
      24'(SETTLE_CYC) : need_same;
   wire gap_ok = !cmd_we_q || is_sel || (gap_q >= need);
   wire data_wr = (state_q == S_GAP) & req_d & we_d & ~is_sel;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_q <= 24'hff_ffff;
         last_q <= 11'h7ff;
         settle_q <= 1'b0;
      end else if (data_wr) begin
         gap_q <= 24'h00_0000;
         last_q <= cmd_addr_q;
         settle_q <= cmd_addr_q == `PRA_TRIM_LSB;
      end else if (gap_q != 24'hff_ffff) begin
         gap_q <= gap_q + 24'h00_0001;
      end
   end

   // ----------------------------------------------------------------
   // link sequencer
   // ----------------------------------------------------------------
   // maps the page first when it differs, then spaces the access
   always_comb begin
      state_d = state_q;
      req_d = 1'b0;
      we_d = we_q;
      addr_d = addr_q;
      wd_d = wd_q;
      case (state_q)
         S_IDLE: begin
            if (go) begin
               state_d = S_START;
            end
         end
         S_START: begin
            state_d = S_GAP;
            if (!is_sel && cmd_addr_q[10:7] != page_q) begin
               req_d = 1'b1;
               we_d = 1'b1;
               addr_d = `PRA_PAGE_SEL;
               wd_d = {4'h0, cmd_addr_q[10:7]};
               state_d = S_PWAIT;
            end
         end
         S_PWAIT: begin
            if (link.ack) begin
               state_d = S_GAP;
            end
         end
         S_GAP: begin
            if (gap_ok) begin
               req_d = 1'b1;
               we_d = cmd_we_q;
               addr_d = cmd_addr_q[6:0];
               wd_d = cmd_wd_q;
               state_d = S_AWAIT;
            end
         end
         S_AWAIT: begin
            if (link.ack) begin
               state_d = S_IDLE;
            end
         end
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= S_IDLE;
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 7'h00;
         wd_q <= 8'h00;
      end else begin
         state_q <= state_d;
         req_q <= req_d;
         we_q <= we_d;
         addr_q <= addr_d;
         wd_q <= wd_d;
      end
   end

   // page mirror and read capture on the answer
   wire acked = link.ack & ((state_q == S_PWAIT) | (state_q == S_AWAIT));

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         page_q <= 4'h0;
         rd_q <= 8'h00;
      end else if (acked) begin
         if (we_q && addr_q == `PRA_PAGE_SEL) begin
            page_q <= wd_q[3:0];
         end
         if (!we_q) begin
            rd_q <= link.rdata;
         end
      end
   end

   assign link.req = req_q;
   assign link.we = we_q;
   assign link.addr = addr_q;
   assign link.wdata = wd_q;

endmodule

// >>> tb/pra_link_asserts.sv
`timescale 1ns/1ps
// --------------------
// link timing checker
// --------------------
module pra_link_asserts #(
   parameter int SAME_GAP_CYC = 20,
   parameter int LOOP_GAP_CYC = 6,
   parameter int SETTLE_CYC = 40
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // link signals
   input wire logic req,
   input wire logic we,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   logic [7:0] pg_q;
   logic [10:0] last_q;
   logic last_e_q;
   logic seen_q;
   int gap_q;

   // decode of link requests against the mirrored page
   wire pg_wr = req && we && addr == 7'h7f;
   wire rd_pg = req && !we && addr == 7'h7f;
   wire data_wr = req && we && addr != 7'h7f;
   wire [10:0] full = {pg_q[3:0], addr};
   wire in_loop = full >= 11'h300 && full <= 11'h31f;
   wire same_wr = data_wr && seen_q && full == last_q;

   // page mirror and distance since last data write; saturates so it never wraps
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pg_q <= 8'h00;
         last_q <= 11'h000;
         last_e_q <= 1'b0;
         seen_q <= 1'b0;
         gap_q <= 0;
      end else begin
         if (pg_wr)
            pg_q <= wdata;
         if (data_wr) begin
            last_q <= full;
            last_e_q <= full == 11'h00e;
            seen_q <= 1'b1;
            gap_q <= 1;
         end else if (gap_q < 1000000) begin
            gap_q <= gap_q + 1;
         end
      end
   end

   // one transfer: request answered on the next cycle
   sequence xfer_s;
      req ##1 ack;
   endsequence

   ack_follows_a: assert property (req |-> xfer_s)
      else $error("ack missing after req");
   ack_cause_a: assert property (ack |-> $past(req))
      else $error("ack without req");
   rdata_hold_a: assert property (!ack || $past(we) |-> $stable(rdata))
      else $error("read byte changed without a read");
   page_readback_a: assert property (rd_pg |=> rdata == pg_q)
      else $error("page register read wrong");
   page_data_a: assert property (pg_wr |-> wdata[7:4] == 4'h0)
      else $error("page write out of range");
   same_gap_a: assert property (same_wr && !in_loop |-> gap_q >= SAME_GAP_CYC - 1)
      else $error("same register rewritten too soon");
   loop_gap_a: assert property (same_wr && in_loop |-> gap_q >= LOOP_GAP_CYC - 1)
      else $error("loop offset rewritten too soon");
   settle_gap_a: assert property (data_wr && last_e_q |-> gap_q >= SETTLE_CYC - 1)
      else $error("write too soon after trim update");
endmodule

// >>> tb/test_paged_register_access_rules.sv
`timescale 1ns/1ps
module test_paged_register_access_rules
   import pra_pkg::*;
;
   // shortened counts keep the run small
   localparam int SAME = 20;
   localparam int LOOP = 6;
   localparam int SETTLE = 40;
   localparam int FINE = 4;
   localparam logic [31:0] NEW_TRIM = 32'h1234_5678;
   // stimulus and observed signals
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [7:0] sticky_event = 8'h00;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [31:0] trim_value;
   logic [7:0] page_sel;
   logic fine_shift_busy;
   logic [31:0] r;
   int error_cnt = 0;
   int checks = 0;
   int fine_n = 0;
   int fine_0 = 0;

   pra_link_if link ();
   // the two ends face each other over one link
   pra_device #(.FINE_UNIT_CYC(FINE)) pra_device_inst (.link(link), .clk(clk), .rst_b(rst_b),
      .sticky_event(sticky_event), .trim_value(trim_value), .page_sel(page_sel),
      .fine_shift_busy(fine_shift_busy));
   pra_host #(.SAME_GAP_CYC(SAME), .LOOP_GAP_CYC(LOOP), .SETTLE_CYC(SETTLE)) pra_host_inst (
      .link(link), .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   pra_link_asserts #(.SAME_GAP_CYC(SAME), .LOOP_GAP_CYC(LOOP), .SETTLE_CYC(SETTLE))
      pra_link_asserts_inst (.clk(clk), .rst_b(rst_b), .req(link.req), .we(link.we),
      .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));

   // clock and busy-cycle counter
   always #5 clk = ~clk;
   always @(posedge clk)
      if (fine_shift_busy === 1'b1)
         fine_n <= fine_n + 1;

   // ----------------
   // report helpers
   // ----------------
   task summarize;
      if (error_cnt == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task fail_wait;
      error_cnt++;
      summarize();
   endtask

   task automatic cmpw(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask

   task automatic cmpb(input string s, input pra_byte_t e, input pra_byte_t g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask

   // ----------------
   // bus access
   // ----------------
   // request held until waitrequest is sampled low; one idle edge avoids double drive
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         n++;
         if (n > 20)
            fail_wait();
         @(posedge clk);
      end
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   // one device access through the controller, polled until not busy
   task automatic op(input pra_addr_t a, input logic w, input pra_byte_t d);
      int n;
      n = 0;
      av(1'b1, 4'h0, {21'h0, a});
      av(1'b1, 4'h4, {24'h0, d});
      av(1'b1, 4'h8, {30'h0, w, 1'b1});
      do begin
         av(1'b0, 4'hc, 32'h0000_0000);
         n++;
         if (n > 60)
            fail_wait();
      end while (r[0] !== 1'b0);
   endtask

   // wide value read msb first, byte by byte
   task automatic trim_rd(input logic [31:0] e);
      for (int i = 0; i < 4; i++) begin
         op(pra_addr_t'(11'h00b + i), 1'b0, 8'h00);
         cmpb("trim byte", e[31 - 8 * i -: 8], r[15:8]);
      end
   endtask

   // ----------------
   // main sequence
   // ----------------
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      cmpw("trim_value", 32'h046a_aaab, trim_value);
      cmpb("page_sel", 8'h00, page_sel);
      trim_rd(32'h046a_aaab);
      cmpb("order flag", 8'h00, {7'h00, r[1]});
      // staged bytes must not reach the applied value before the lsb
      for (int i = 0; i < 4; i++) begin
         op(pra_addr_t'(11'h00b + i), 1'b1, NEW_TRIM[31 - 8 * i -: 8]);
         if (i < 3)
            cmpw("trim held", 32'h046a_aaab, trim_value);
      end
      cmpw("trim applied", NEW_TRIM, trim_value);
      trim_rd(NEW_TRIM);
      op(11'h00d, 1'b0, 8'h00);
      cmpb("order flag", 8'h01, {7'h00, r[1]});
      av(1'b1, 4'hc, 32'h0000_0002);
      av(1'b0, 4'hc, 32'h0000_0000);
      cmpb("order clear", 8'h00, {7'h00, r[1]});
      av(1'b0, 4'h2, 32'h0000_0000);
      cmpw("unmapped", 32'h0000_0000, r);
      // two units of fine shift, then zero units
      for (int n = 2; n >= 0; n -= 2) begin
         fine_0 = fine_n;
         op(11'h420, 1'b1, pra_byte_t'(n));
         repeat (4 * FINE) @(posedge clk);
         cmpw("fine busy cycles", 32'(n * FINE), 32'(fine_n - fine_0));
      end
      cmpb("page_sel", 8'h08, page_sel);
      op(11'h47f, 1'b0, 8'h00);
      cmpb("page readback", 8'h08, r[15:8]);
      // sticky bits: a clear without hold must not take
      sticky_event <= 8'h05;
      @(posedge clk);
      sticky_event <= 8'h00;
      op(11'h181, 1'b1, 8'h00);
      op(11'h181, 1'b0, 8'h00);
      cmpb("sticky unheld", 8'h05, r[15:8]);
      op(11'h180, 1'b1, 8'h01);
      op(11'h181, 1'b1, 8'h00);
      op(11'h180, 1'b1, 8'h00);
      repeat (SAME) @(posedge clk);
      op(11'h181, 1'b0, 8'h00);
      cmpb("sticky cleared", 8'h00, r[15:8]);
      op(11'h180, 1'b0, 8'h00);
      cmpb("hold register", 8'h00, r[15:8]);
      // selector rewritten with no spacing between the two writes
      op(11'h07f, 1'b1, 8'h02);
      op(11'h07f, 1'b1, 8'h05);
      cmpb("page_sel", 8'h05, page_sel);
      op(11'h300, 1'b1, 8'h01);
      op(11'h300, 1'b1, 8'h02);
      summarize();
   end
endmodule
